/* logic/pie_pkg.sv */
package pie_pkg;

  // Sizes
  localparam int PIE_NSRC = 19;
  localparam int PIE_NLVL = 6;
  localparam int PIE_NEV = 5;
  localparam int PIE_AW = 17;

  // Register indices; byte address is four times the index
  localparam logic [14:0] PIE_IDX_SYSVEC = 15'h701E;
  localparam logic [14:0] PIE_IDX_GRPB = 15'h7433;
  localparam logic [14:0] PIE_IDX_GRPC = 15'h7434;
  localparam logic [14:0] PIE_IDX_LVLMASK = 15'h7440;
  localparam logic [14:0] PIE_IDX_CTRL = 15'h7441;
  localparam logic [14:0] PIE_IDX_STAT = 15'h7442;
  localparam logic [14:0] PIE_IDX_IRQMASK = 15'h7443;
  localparam logic [14:0] PIE_IDX_PEND = 15'h7444;

  // Field positions
  localparam int PIE_CTRL_GLOBAL_MASKABLE_DISABLE_BIT = 0;
  localparam int PIE_EV_MASKABLE = 0;
  localparam int PIE_EV_NMI = 1;
  localparam int PIE_EV_SOFT = 2;
  localparam int PIE_EV_TRAP = 3;
  localparam int PIE_EV_PHANTOM = 4;

  // Reset values
  localparam logic [5:0] PIE_RST_LVLMASK = 6'h00;
  localparam logic PIE_RST_GLOBAL_MASKABLE_DISABLE = 1'b1;
  localparam logic [15:0] PIE_RST_VEC = 16'h0000;
  localparam logic [4:0] PIE_RST_IRQMASK = 5'h00;

  // Fixed vectors
  localparam logic [15:0] PIE_VEC_NMI = 16'h0024;
  localparam logic [15:0] PIE_VEC_TRAP = 16'h0022;
  localparam logic [15:0] PIE_VEC_PHANTOM = 16'h0000;

  // Core levels that own a vector register here
  localparam logic [2:0] PIE_LVL_ONE = 3'h1;
  localparam logic [2:0] PIE_LVL_GRPB = 3'h3;
  localparam logic [2:0] PIE_LVL_GRPC = 3'h4;
  localparam logic [2:0] PIE_LVL_SYS5 = 3'h5;
  localparam logic [2:0] PIE_LVL_SYS6 = 3'h6;

  // Per source offset, index 0 is overall priority 22, index 18 is 40
  localparam logic [PIE_NSRC-1:0][15:0] PIE_SRC_OFS = {
    16'h001F, 16'h0011, 16'h0001, 16'h0004,
    16'h0007, 16'h0006, 16'h0005,
    16'h0036, 16'h0035, 16'h0034, 16'h0033,
    16'h0032, 16'h0031, 16'h0030, 16'h002F,
    16'h002E, 16'h002D, 16'h002C, 16'h002B};

  // Per source core level
  localparam logic [PIE_NSRC-1:0][2:0] PIE_SRC_LVL = {
    3'h6, 3'h6, 3'h6, 3'h6,
    3'h5, 3'h5, 3'h5,
    3'h4, 3'h4, 3'h4, 3'h4,
    3'h3, 3'h3, 3'h3, 3'h3,
    3'h3, 3'h3, 3'h3, 3'h3};

endpackage

/* logic/pie_first_set.sv */
`timescale 1ns/10ps
module pie_first_set
  import pie_pkg::*;
#(
  parameter int N = 19,
  parameter int W = 5
) (
  input wire logic [N-1:0] req, // Candidate lines, bit 0 ranks first
  output logic any, // Some line set
  output logic [W-1:0] idx // Lowest set index
);

  // Scan downward so the lowest index is written last and wins
  always_comb begin
    any = 1'b0;
    idx = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i]) begin
        any = 1'b1;
        idx = W'(i);
      end
    end
  end

endmodule

/* logic/pie_expander.sv */
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/10ps
module pie_expander
  import pie_pkg::*;
(
  input wire logic sys_clk, // 125 MHz system clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction, high for write
  input wire logic [PIE_AW-1:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error, unmapped address
  input wire logic timer2PeriodIrq, // Event pulses from on-chip timers
  input wire logic timer2CompareIrq, // Timer 2 compare
  input wire logic timer2UnderflowIrq, // Timer 2 underflow
  input wire logic timer2OverflowIrq, // Timer 2 overflow
  input wire logic timer3PeriodIrq, // Timer 3 period
  input wire logic timer3CompareIrq, // Timer 3 compare
  input wire logic timer3UnderflowIrq, // Timer 3 underflow
  input wire logic timer3OverflowIrq, // Timer 3 overflow
  input wire logic capture1Irq, // Capture unit 1
  input wire logic capture2Irq, // Capture unit 2
  input wire logic capture3Irq, // Capture unit 3
  input wire logic capture4Irq, // Capture unit 4
  input wire logic serialPeriphIrq, // Serial peripheral, low priority
  input wire logic serialReceiveIrq, // Serial receive, low priority
  input wire logic serialTransmitIrq, // Serial transmit, low priority
  input wire logic converterDoneIrq, // Converter done
  input wire logic extPin1Irq, // Pin, asynchronous
  input wire logic extPin2Irq, // Pin, asynchronous
  input wire logic extPin3Irq, // Pin, asynchronous
  input wire logic coreLevelOneReq, // Level 1 request from other logic
  input wire logic coreLevelTwoReq, // Level 2 request from other logic
  input wire logic nmiPin, // Nonmaskable pin, asynchronous
  input wire logic swReq, // Core software interrupt pulse
  input wire logic [4:0] swNum, // Interrupt number of swReq
  input wire logic swTrap, // swReq comes from the trap instruction
  output logic ackPulse, // One cycle acknowledge to the core
  output logic [15:0] ackVector, // Vector location to branch to
  output logic [2:0] ackLevel, // Maskable level taken, zero otherwise
  output logic [5:0] coreLevelReq, // Pending unmasked levels 1 to 6
  output logic globalMaskableDisable, // Global maskable disable flag
  output logic irq // Level interrupt from status and mask
);

  // Register state
  logic [31:0] prdata_ff, nxt_prdata;
  logic pready_ff, pslverr_ff;
  logic [5:0] levelMaskRegister_ff, nxt_levelMaskRegister;
  logic global_maskable_disable_ff, nxt_global_maskable_disable;
  logic [PIE_NEV-1:0] stat_ff, nxt_stat;
  logic [PIE_NEV-1:0] irqMask_ff, nxt_irqMask;
  logic [PIE_NSRC-1:0] pend_ff, nxt_pend;
  logic [15:0] systemVectorOffset_ff, nxt_systemVectorOffset;
  logic [15:0] groupBVectorOffset_ff, nxt_groupBVectorOffset;
  logic [15:0] groupCVectorOffset_ff, nxt_groupCVectorOffset;
  logic ackPulse_ff;
  logic [15:0] ackVector_ff, nxt_ackVector;
  logic [2:0] ackLevel_ff;
  logic [5:0] coreLevelReq_ff;
  logic irq_ff;

  // Pin synchronisers and edge detect state
  logic [2:0] extSync1_ff, extSync2_ff, extDly_ff;
  logic nmiSync1_ff, nmiSync2_ff, nmiDly_ff;
  logic nmiPend_ff, nxt_nmiPend;

  // Pins first cross two flops; only the second stage feeds logic
  always_ff @(posedge sys_clk) begin
    extSync1_ff <= {extPin3Irq, extPin2Irq, extPin1Irq};
    extSync2_ff <= extSync1_ff;
    nmiSync1_ff <= nmiPin;
    nmiSync2_ff <= nmiSync1_ff;
  end

  // Rising edges of synchronised pins
  logic [2:0] extEdge;
  logic nmiEdge;
  assign extEdge = extSync2_ff & ~extDly_ff;
  assign nmiEdge = nmiSync2_ff & ~nmiDly_ff;

  // Source events in overall priority order, bit 0 first
  logic [PIE_NSRC-1:0] srcEvt;
  assign srcEvt = {extEdge, converterDoneIrq,
    serialTransmitIrq, serialReceiveIrq, serialPeriphIrq,
    capture4Irq, capture3Irq, capture2Irq, capture1Irq,
    timer3OverflowIrq, timer3UnderflowIrq, timer3CompareIrq, timer3PeriodIrq,
    timer2OverflowIrq, timer2UnderflowIrq, timer2CompareIrq, timer2PeriodIrq};

  // Level membership of each source, from the fixed routing table
  logic [PIE_NLVL-1:0][PIE_NSRC-1:0] member;
  logic [PIE_NLVL-1:0] srcLvlPend;
  genvar g, s;
  generate
    for (g = 0; g < PIE_NLVL; g++) begin : gLvl
      for (s = 0; s < PIE_NSRC; s++) begin : gSrc
        assign member[g][s] = (PIE_SRC_LVL[s] == 3'(g + 1));
      end
      assign srcLvlPend[g] = |(pend_ff & member[g]);
    end
  endgenerate

  // Merge peripheral and outside requests onto six levels
  logic [PIE_NLVL-1:0] lvlPend, lvlOk;
  assign lvlPend = srcLvlPend | {4'h0, coreLevelTwoReq, coreLevelOneReq};
  // Mask bit one unmasks; the global flag blocks every level
  assign lvlOk = lvlPend & levelMaskRegister_ff & {PIE_NLVL{~global_maskable_disable_ff}};

  // Highest priority level wins; lowest number ranks first
  logic lvlAny;
  logic [2:0] lvlIdx;
  pie_first_set #(.N(PIE_NLVL), .W(3)) uLvlPick (
    .req(lvlOk),
    .any(lvlAny),
    .idx(lvlIdx)
  );

  logic [2:0] winLvl;
  assign winLvl = lvlIdx + 3'h1;

  // Within the chosen level the lowest priority number wins
  logic [PIE_NSRC-1:0] srcCand;
  logic srcAny;
  logic [4:0] srcIdx;
  assign srcCand = pend_ff & member[lvlIdx];
  pie_first_set #(.N(PIE_NSRC), .W(5)) uSrcPick (
    .req(srcCand),
    .any(srcAny),
    .idx(srcIdx)
  );

  logic [15:0] winOfs;
  assign winOfs = PIE_SRC_OFS[srcIdx];

  // One acknowledge per cycle: software, then NMI, then maskable.
  // The core issues one instruction at a time, so software never waits.
  logic takeSw, takeTrap, takeIntr, takeNmi, takeMask;
  assign takeSw = swReq;
  assign takeTrap = swReq & swTrap;
  assign takeIntr = swReq & ~swTrap;
  assign takeNmi = nmiPend_ff & ~swReq;
  assign takeMask = lvlAny & ~swReq & ~nmiPend_ff;

  // Branch target of the taken request
  always_comb begin
    if (takeTrap) begin
      nxt_ackVector = PIE_VEC_TRAP;
    end else if (takeIntr) begin
      nxt_ackVector = {10'h000, swNum, 1'b0};
    end else if (takeNmi) begin
      nxt_ackVector = PIE_VEC_NMI;
    end else begin
      nxt_ackVector = {12'h000, winLvl, 1'b0};
    end
  end

  // Software request to a level that owns a vector register has no source behind it
  logic phanSys, phanB, phanC, phantom;
  assign phanSys = takeIntr & (swNum == 5'(PIE_LVL_ONE) | swNum == 5'(PIE_LVL_SYS5)
    | swNum == 5'(PIE_LVL_SYS6));
  assign phanB = takeIntr & (swNum == 5'(PIE_LVL_GRPB));
  assign phanC = takeIntr & (swNum == 5'(PIE_LVL_GRPC));
  assign phantom = phanSys | phanB | phanC;

  // Peripheral source that supplies a vector this cycle
  logic loadSys, loadB, loadC;
  assign loadSys = takeMask & srcAny & (winLvl == PIE_LVL_SYS5 | winLvl == PIE_LVL_SYS6);
  assign loadB = takeMask & srcAny & (winLvl == PIE_LVL_GRPB);
  assign loadC = takeMask & srcAny & (winLvl == PIE_LVL_GRPC);

  // Vector registers keep their value until an acknowledge or software request of their own levels
  always_comb begin
    nxt_systemVectorOffset = systemVectorOffset_ff;
    nxt_groupBVectorOffset = groupBVectorOffset_ff;
    nxt_groupCVectorOffset = groupCVectorOffset_ff;
    if (loadSys) begin
      nxt_systemVectorOffset = winOfs;
    end else if (phanSys) begin
      nxt_systemVectorOffset = PIE_VEC_PHANTOM;
    end
    if (loadB) begin
      nxt_groupBVectorOffset = winOfs;
    end else if (phanB) begin
      nxt_groupBVectorOffset = PIE_VEC_PHANTOM;
    end
    if (loadC) begin
      nxt_groupCVectorOffset = winOfs;
    end else if (phanC) begin
      nxt_groupCVectorOffset = PIE_VEC_PHANTOM;
    end
  end

  // Pending sources: a new event beats the clear of the same bit
  logic [PIE_NSRC-1:0] pendClr;
  generate
    for (s = 0; s < PIE_NSRC; s++) begin : gClr
      assign pendClr[s] = takeMask & srcAny & (srcIdx == 5'(s));
    end
  endgenerate
  assign nxt_pend = (pend_ff & ~pendClr) | srcEvt;

  // NMI edge waits only while a software request is taken
  assign nxt_nmiPend = nmiEdge | (nmiPend_ff & ~takeNmi);

  // APB decode, no wait state; read data comes from a flop loaded in setup
  logic setupPh, accessPh, aligned, hit, wrEn, rdStat;
  logic [14:0] idx;
  assign idx = paddr[PIE_AW-1:2];
  assign aligned = (paddr[1:0] == 2'h0);
  assign setupPh = psel & ~penable;
  assign accessPh = psel & penable & pready_ff;
  assign hit = aligned & (idx == PIE_IDX_SYSVEC | idx == PIE_IDX_GRPB
    | idx == PIE_IDX_GRPC | idx == PIE_IDX_LVLMASK | idx == PIE_IDX_CTRL
    | idx == PIE_IDX_STAT | idx == PIE_IDX_IRQMASK | idx == PIE_IDX_PEND);
  assign wrEn = accessPh & pwrite & hit;
  assign rdStat = accessPh & ~pwrite & aligned & (idx == PIE_IDX_STAT);

  // Read mux, captured in the setup cycle; unused bits read zero
  assign nxt_prdata = ~aligned ? 32'h0000_0000
    : idx == PIE_IDX_SYSVEC ? {16'h0000, systemVectorOffset_ff}
    : idx == PIE_IDX_GRPB ? {16'h0000, groupBVectorOffset_ff}
    : idx == PIE_IDX_GRPC ? {16'h0000, groupCVectorOffset_ff}
    : idx == PIE_IDX_LVLMASK ? {26'h0, levelMaskRegister_ff}
    : idx == PIE_IDX_CTRL ? {31'h0, global_maskable_disable_ff}
    : idx == PIE_IDX_STAT ? {27'h0, stat_ff}
    : idx == PIE_IDX_IRQMASK ? {27'h0, irqMask_ff}
    : idx == PIE_IDX_PEND ? {13'h0, pend_ff}
    : 32'h0000_0000;

  // Software writes; vector registers ignore writes
  assign nxt_levelMaskRegister = (wrEn & idx == PIE_IDX_LVLMASK)
    ? pwdata[PIE_NLVL-1:0] : levelMaskRegister_ff;
  assign nxt_irqMask = (wrEn & idx == PIE_IDX_IRQMASK)
    ? pwdata[PIE_NEV-1:0] : irqMask_ff;

  // Any acknowledge but the trap sets the flag, winning over a clear
  logic anyAck;
  assign anyAck = takeSw | takeNmi | takeMask;
  assign nxt_global_maskable_disable = (anyAck & ~takeTrap) ? 1'b1
    : (wrEn & idx == PIE_IDX_CTRL) ? pwdata[PIE_CTRL_GLOBAL_MASKABLE_DISABLE_BIT] : global_maskable_disable_ff;

  // Sticky events; a read clears only the bits it returned
  logic [PIE_NEV-1:0] evt, statClr;
  assign evt[PIE_EV_MASKABLE] = takeMask;
  assign evt[PIE_EV_NMI] = takeNmi;
  assign evt[PIE_EV_SOFT] = takeIntr;
  assign evt[PIE_EV_TRAP] = takeTrap;
  assign evt[PIE_EV_PHANTOM] = phantom;
  assign statClr = rdStat ? prdata_ff[PIE_NEV-1:0] : '0;
  assign nxt_stat = (stat_ff & ~statClr) | evt;

  // Bus slave flops
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      prdata_ff <= 32'h0000_0000;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff <= setupPh;
      pslverr_ff <= setupPh & ~hit;
      if (setupPh) begin
        prdata_ff <= nxt_prdata;
      end
    end
  end

  // Software visible registers
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      levelMaskRegister_ff <= PIE_RST_LVLMASK;
      global_maskable_disable_ff <= PIE_RST_GLOBAL_MASKABLE_DISABLE;
      irqMask_ff <= PIE_RST_IRQMASK;
      stat_ff <= '0;
    end else begin
      levelMaskRegister_ff <= nxt_levelMaskRegister;
      global_maskable_disable_ff <= nxt_global_maskable_disable;
      irqMask_ff <= nxt_irqMask;
      stat_ff <= nxt_stat;
    end
  end

  // Vector registers
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      systemVectorOffset_ff <= PIE_RST_VEC;
      groupBVectorOffset_ff <= PIE_RST_VEC;
      groupCVectorOffset_ff <= PIE_RST_VEC;
    end else begin
      systemVectorOffset_ff <= nxt_systemVectorOffset;
      groupBVectorOffset_ff <= nxt_groupBVectorOffset;
      groupCVectorOffset_ff <= nxt_groupCVectorOffset;
    end
  end

  // Pending state and pin edge history
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pend_ff <= '0;
      nmiPend_ff <= 1'b0;
      extDly_ff <= 3'h0;
      nmiDly_ff <= 1'b0;
    end else begin
      pend_ff <= nxt_pend;
      nmiPend_ff <= nxt_nmiPend;
      extDly_ff <= extSync2_ff;
      nmiDly_ff <= nmiSync2_ff;
    end
  end

  // Core facing outputs, all registered
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ackPulse_ff <= 1'b0;
      ackVector_ff <= 16'h0000;
      ackLevel_ff <= 3'h0;
      coreLevelReq_ff <= 6'h00;
      irq_ff <= 1'b0;
    end else begin
      ackPulse_ff <= anyAck;
      if (anyAck) begin
        ackVector_ff <= nxt_ackVector;
      end
      ackLevel_ff <= takeMask ? winLvl : 3'h0;
      coreLevelReq_ff <= lvlPend & levelMaskRegister_ff;
      irq_ff <= |(stat_ff & irqMask_ff);
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign ackPulse = ackPulse_ff;
  assign ackVector = ackVector_ff;
  assign ackLevel = ackLevel_ff;
  assign coreLevelReq = coreLevelReq_ff;
  assign globalMaskableDisable = global_maskable_disable_ff;
  assign irq = irq_ff;

endmodule

/* dv/pie_checker.sv */
`timescale 1ns/10ps
module pie_checker (
  input wire logic sys_clk, // Clock
  input wire logic rst_n, // Reset, active low
  input wire logic psel, // Select
  input wire logic penable, // Enable
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  input wire logic swReq, // Software request
  input wire logic [4:0] swNum, // Software number
  input wire logic swTrap, // Trap flavour
  input wire logic ackPulse, // Acknowledge
  input wire logic [15:0] ackVector, // Branch target
  input wire logic [2:0] ackLevel, // Level taken
  input wire logic globalMaskableDisable // Global flag
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Bus answers one cycle after setup, never while idle
  AST_APB_READY: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  AST_READY_ONE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_IDLE_QUIET: assert property (!psel |=> !pready)
    else $error("pready without request");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("pslverr outside access");
  // Maskable acks branch to twice the level
  AST_LVL_VEC: assert property (ackPulse && ackLevel != 3'h0 |-> ackVector == {12'h000, ackLevel, 1'b0})
    else $error("level vector wrong");
  AST_MASK_FLAG: assert property (ackPulse && ackLevel != 3'h0 |-> !$past(globalMaskableDisable))
    else $error("maskable ack while disabled");
  // Software requests never wait
  AST_SW_NOW: assert property (swReq |=> ackPulse && ackVector == {10'h000, $past(swNum), 1'b0})
    else $error("software ack late or wrong");
  AST_TRAP_FLAG: assert property (swReq && swTrap |=> $stable(globalMaskableDisable))
    else $error("trap changed flag");
  AST_ACK_FLAG: assert property (ackPulse && !($past(swReq) && $past(swTrap)) |-> globalMaskableDisable)
    else $error("flag not set on ack");
  COV_MASKABLE: cover property (ackPulse && ackLevel != 3'h0);
  COV_TRAP: cover property (swReq && swTrap);
  COV_ERR: cover property (pslverr);
endmodule
bind pie_expander pie_checker chk (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .swReq(swReq), .swNum(swNum),
  .swTrap(swTrap), .ackPulse(ackPulse), .ackVector(ackVector), .ackLevel(ackLevel),
  .globalMaskableDisable(globalMaskableDisable));

/* dv/pie_core_model.sv */
`timescale 1ns/10ps
module pie_core_model (
  input wire logic sys_clk, // Clock
  input wire logic ackPulse, // Acknowledge
  input wire logic [15:0] ackVector, // Branch target
  input wire logic [2:0] ackLevel, // Level taken
  output logic swReq, // Software request
  output logic [4:0] swNum, // Software number
  output logic swTrap, // Trap flavour
  output logic nmiPin, // Nonmaskable pin
  output logic coreLevelOneReq, // Level 1 request
  output logic coreLevelTwoReq // Level 2 request
);
  logic [1:0] lvlReq = 2'b00;
  int ackCnt = 0;
  logic [15:0] lastVec;
  logic [2:0] lastLvl;
  assign coreLevelOneReq = lvlReq[0];
  assign coreLevelTwoReq = lvlReq[1];
  initial begin
    swReq = 1'b0;
    swNum = 5'h00;
    swTrap = 1'b0;
    nmiPin = 1'b0;
  end
  // Latch each ack; the bench counts them instead of racing the pulse
  always @(posedge sys_clk) begin
    if (ackPulse === 1'b1) begin
      ackCnt <= ackCnt + 1;
      lastVec <= ackVector;
      lastLvl <= ackLevel;
    end
  end
  // One cycle request; number inverted after so stale values show
  task issue_sw(input logic [4:0] n, input logic t);
    @(posedge sys_clk);
    swReq <= 1'b1;
    swNum <= n;
    swTrap <= t;
    @(posedge sys_clk);
    swReq <= 1'b0;
    swNum <= ~n;
    swTrap <= ~t;
  endtask
  // Held for three cycles to pass the pin synchroniser
  task pulse_nmi;
    nmiPin <= 1'b1;
    repeat (3) @(posedge sys_clk);
    nmiPin <= 1'b0;
  endtask
endmodule

/* dv/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
  import pie_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, err;
  logic [PIE_AW-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [18:0] src, s;
  logic [15:0] ackVector;
  logic [2:0] ackLevel;
  logic [5:0] coreLevelReq;
  logic ackPulse, globalMaskableDisable, irq, swReq, swTrap, nmiPin, l1, l2;
  logic [4:0] swNum;
  int miscompares = 0;
  int n_tests = 0;
  int cyc = 0;
  int i, j, n0;
  integer seed = 32'h92105085;
  logic [14:0] ra[6] = '{PIE_IDX_SYSVEC, PIE_IDX_GRPB, PIE_IDX_GRPC, PIE_IDX_LVLMASK,
    PIE_IDX_CTRL, PIE_IDX_IRQMASK};
  logic [31:0] rv[6] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h1, 32'h0};

  always #4 sys_clk = ~sys_clk;

  pie_expander DUT (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer2PeriodIrq(src[0]), .timer2CompareIrq(src[1]),
    .timer2UnderflowIrq(src[2]), .timer2OverflowIrq(src[3]), .timer3PeriodIrq(src[4]),
    .timer3CompareIrq(src[5]), .timer3UnderflowIrq(src[6]), .timer3OverflowIrq(src[7]),
    .capture1Irq(src[8]), .capture2Irq(src[9]), .capture3Irq(src[10]),
    .capture4Irq(src[11]), .serialPeriphIrq(src[12]), .serialReceiveIrq(src[13]),
    .serialTransmitIrq(src[14]), .converterDoneIrq(src[15]), .extPin1Irq(src[16]),
    .extPin2Irq(src[17]), .extPin3Irq(src[18]), .coreLevelOneReq(l1),
    .coreLevelTwoReq(l2), .nmiPin(nmiPin), .swReq(swReq), .swNum(swNum), .swTrap(swTrap),
    .ackPulse(ackPulse), .ackVector(ackVector), .ackLevel(ackLevel),
    .coreLevelReq(coreLevelReq), .globalMaskableDisable(globalMaskableDisable), .irq(irq));

  pie_core_model core (.sys_clk(sys_clk), .ackPulse(ackPulse), .ackVector(ackVector),
    .ackLevel(ackLevel), .swReq(swReq), .swNum(swNum), .swTrap(swTrap), .nmiPin(nmiPin),
    .coreLevelOneReq(l1), .coreLevelTwoReq(l2));

  // Expected level and offset per source, priority order
  function automatic logic [2:0] lvl_of(input int n);
    return (n < 8) ? 3'h3 : (n < 12) ? 3'h4 : (n < 15) ? 3'h5 : 3'h6;
  endfunction
  function automatic logic [15:0] ofs_of(input int n);
    case (n)
      15: return 16'h0004;
      16: return 16'h0001;
      17: return 16'h0011;
      18: return 16'h001F;
      default: return (n < 12) ? 16'h002B + 16'(n) : 16'h0005 + 16'(n - 12);
    endcase
  endfunction
  function automatic logic [14:0] reg_of(input logic [2:0] l);
    return (l == 3'h3) ? PIE_IDX_GRPB : (l == 3'h4) ? PIE_IDX_GRPC : PIE_IDX_SYSVEC;
  endfunction

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Setup then access, held until pready is seen at an edge
  task apb(input logic w, input logic [14:0] x, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {x, 2'b00};
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    // Ends on pready; with no local limit, only the bench timeout stops a hang
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wait_ack(input int n);
    int t;
    for (t = 0; t < 40 && core.ackCnt == n; t++) @(posedge sys_clk);
    chk("ack seen", 32'h1, {31'h0, core.ackCnt != n});
  endtask
  // Sources held three cycles so pins clear the synchroniser
  task pulse(input logic [18:0] v);
    src <= v;
    repeat (3) @(posedge sys_clk);
    src <= 19'h0;
  endtask
  // Load a set while disabled, then release one ack at a time
  task drain(input logic [18:0] v);
    s = v;
    apb(1'b1, PIE_IDX_LVLMASK, 32'h3F);
    pulse(v);
    repeat (8) @(posedge sys_clk);
    apb(1'b0, PIE_IDX_PEND, 32'h0);
    chk("pending", {13'h0, v}, rd);
    while (s != 19'h0) begin
      for (i = 0; !s[i]; i++) begin
      end
      n0 = core.ackCnt;
      apb(1'b1, PIE_IDX_CTRL, 32'h0);
      wait_ack(n0);
      chk("ack vector", {28'h0, lvl_of(i), 1'b0}, {16'h0, core.lastVec});
      chk("ack level", {29'h0, lvl_of(i)}, {29'h0, core.lastLvl});
      chk("flag set", 32'h1, {31'h0, globalMaskableDisable});
      apb(1'b0, reg_of(lvl_of(i)), 32'h0);
      chk("vector reg", {16'h0, ofs_of(i)}, rd);
      s[i] = 1'b0;
    end
  endtask

  task end_of_test;
    $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Cut a hang short
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      miscompares++;
      end_of_test;
    end
  end

  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    src = 19'h0;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    // Reset values; vector register ignores writes
    apb(1'b1, PIE_IDX_SYSVEC, 32'hFFFF);
    for (j = 0; j < 6; j++) begin
      apb(1'b0, ra[j], 32'h0);
      chk("reset value", rv[j], rd);
    end
    apb(1'b0, 15'h0001, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
    drain(19'h7FFFF);
    for (j = 0; j < 3; j++) drain(19'($random(seed)) | (19'h1 << (j * 7)));
    // Masked level waits, then goes once unmasked
    apb(1'b1, PIE_IDX_LVLMASK, 32'h37);
    apb(1'b1, PIE_IDX_CTRL, 32'h0);
    n0 = core.ackCnt;
    pulse(19'h00100);
    repeat (10) @(posedge sys_clk);
    chk("masked no ack", n0, core.ackCnt);
    chk("masked level", 32'h0, {31'h0, coreLevelReq[3]});
    apb(1'b1, PIE_IDX_LVLMASK, 32'h3F);
    wait_ack(n0);
    chk("unmasked level", 32'h4, {29'h0, core.lastLvl});
    // Flag blocks maskable but not software; INTR 3 loads phantom
    n0 = core.ackCnt;
    pulse(19'h00001);
    repeat (10) @(posedge sys_clk);
    chk("flag blocks", n0, core.ackCnt);
    chk("level pending", 32'h1, {31'h0, coreLevelReq[2]});
    core.issue_sw(5'h03, 1'b0);
    wait_ack(n0);
    chk("sw vector", 32'h6, {16'h0, core.lastVec});
    apb(1'b0, PIE_IDX_GRPB, 32'h0);
    chk("phantom", 32'h0, rd);
    apb(1'b0, PIE_IDX_STAT, 32'h0);
    chk("status", 32'h15, rd & 32'h15);
    n0 = core.ackCnt;
    core.issue_sw(5'h05, 1'b0);
    wait_ack(n0);
    apb(1'b0, PIE_IDX_SYSVEC, 32'h0);
    chk("phantom sys", 32'h0, rd);
    n0 = core.ackCnt;
    apb(1'b1, PIE_IDX_CTRL, 32'h0);
    wait_ack(n0);
    apb(1'b0, PIE_IDX_GRPB, 32'h0);
    chk("kept pending", 32'h2B, rd);
    // Trap leaves flag clear; NMI ignores masks and sets it
    apb(1'b1, PIE_IDX_LVLMASK, 32'h0);
    apb(1'b1, PIE_IDX_CTRL, 32'h0);
    n0 = core.ackCnt;
    core.issue_sw(5'h11, 1'b1);
    wait_ack(n0);
    chk("trap vector", 32'h22, {16'h0, core.lastVec});
    chk("trap flag", 32'h0, {31'h0, globalMaskableDisable});
    apb(1'b1, PIE_IDX_IRQMASK, 32'h1);
    apb(1'b0, PIE_IDX_STAT, 32'h0);
    n0 = core.ackCnt;
    core.pulse_nmi;
    wait_ack(n0);
    chk("nmi vector", 32'h24, {16'h0, core.lastVec});
    chk("nmi flag", 32'h1, {31'h0, globalMaskableDisable});
    repeat (3) @(posedge sys_clk);
    chk("irq masked", 32'h0, {31'h0, irq});
    // Level one request raises the interrupt output, read clears it
    apb(1'b1, PIE_IDX_LVLMASK, 32'h1);
    n0 = core.ackCnt;
    apb(1'b1, PIE_IDX_CTRL, 32'h0);
    core.lvlReq <= 2'b01;
    wait_ack(n0);
    core.lvlReq <= 2'b00;
    chk("level one", 32'h2, {16'h0, core.lastVec});
    repeat (3) @(posedge sys_clk);
    chk("irq raised", 32'h1, {31'h0, irq});
    apb(1'b0, PIE_IDX_STAT, 32'h0);
    repeat (3) @(posedge sys_clk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    end_of_test;
  end
endmodule
